// file: core/sac_pkg.sv
`default_nettype none
package sac_pkg;

  // ****************************************************
  // Register offsets.
  // ****************************************************
  localparam logic [7:0] SAC_CTRL2_OFS = 8'h00;
  localparam logic [7:0] SAC_CTRL1_OFS = 8'h04;
  localparam logic [7:0] SAC_STAT_OFS = 8'h08;
  localparam logic [7:0] SAC_MASK_OFS = 8'h0c;
  localparam logic [7:0] SAC_TXD_OFS = 8'h10;
  localparam logic [7:0] SAC_RXD_OFS = 8'h14;

  // ****************************************************
  // Field positions of the second control register.
  // ****************************************************
  localparam int SAC_SGNEXT_BIT = 15;
  localparam int SAC_FRMEN_BIT = 12;
  localparam int SAC_ROVEN_BIT = 11;
  localparam int SAC_TUREN_BIT = 10;
  localparam int SAC_IGNORE_RX_OVERFLOW_BIT = 9;
  localparam int SAC_IGNORE_TX_UNDERRUN_BIT = 8;
  localparam int SAC_AUDIO_ENABLE_BIT = 7;
  localparam int SAC_MONO_BIT = 3;
  localparam int SAC_MODE_LSB = 0;
  localparam logic [15:0] SAC_CTRL2_RESET = 16'h0000;
  localparam logic [15:0] SAC_CTRL2_MASK = 16'h9f8b;

  // ****************************************************
  // Status bits and first control register fields.
  // ****************************************************
  localparam int SAC_ON_BIT = 0;
  localparam int SAC_ST_FRM = 0;
  localparam int SAC_ST_ROV = 1;
  localparam int SAC_ST_TUR = 2;
  localparam int SAC_ST_HALT = 3;
  localparam int SAC_ST_RXV = 4;
  localparam int SAC_ST_TXE = 5;

  // ****************************************************
  // Audio modes.
  // ****************************************************
  localparam logic [1:0] SAC_MODE_I2S = 2'h0;
  localparam logic [1:0] SAC_MODE_LJ = 2'h1;
  localparam logic [1:0] SAC_MODE_RJ = 2'h2;
  localparam logic [1:0] SAC_MODE_PCM = 2'h3;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SHIFT,
    SAC_HALT
  } sac_state_type;

endpackage
`default_nettype wire

// file: core/sac_core.sv
`timescale 1ns/10ps
`default_nettype none
module sac_core
  import sac_pkg::*;
#(
  parameter int WORD_W = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link.
  input wire logic link_sck,
  input wire logic link_ws,
  input wire logic link_sdi,
  output logic link_sdo,
  output logic link_chan,
  // Interrupt.
  output logic irq
);

  // ****************************************************
  // Registers.
  // ****************************************************
  logic [15:0] ctrl2_q;
  logic on_q;
  logic [5:0] stat_q;
  logic [5:0] mask_q;
  logic [WORD_W-1:0] txb_q, rxb_q, tsh_q, rsh_q;
  logic txf_q, rxf_q, right_q, mono_rep_q;
  logic [2:0] sck_s_q, ws_s_q, sdi_s_q;
  logic [$clog2(WORD_W+1)-1:0] cnt_q;
  sac_state_type st_q;

  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire mapped = paddr inside {SAC_CTRL2_OFS, SAC_CTRL1_OFS, SAC_STAT_OFS,
    SAC_MASK_OFS, SAC_TXD_OFS, SAC_RXD_OFS};
  wire audio = ctrl2_q[SAC_AUDIO_ENABLE_BIT];
  wire mono = audio && ctrl2_q[SAC_MONO_BIT];
  wire [1:0] mode = audio ? ctrl2_q[SAC_MODE_LSB+:2] : SAC_MODE_I2S;

  // ****************************************************
  // Synchronisers and edge detection.
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s_q <= 3'h0;
      ws_s_q <= 3'h0;
      sdi_s_q <= 3'h0;
    end else begin
      sck_s_q <= {sck_s_q[1:0], link_sck};
      ws_s_q <= {ws_s_q[1:0], link_ws};
      sdi_s_q <= {sdi_s_q[1:0], link_sdi};
    end
  end
  wire rise = sck_s_q[1] && !sck_s_q[2];
  wire fall = !sck_s_q[1] && sck_s_q[2];
  wire ws_edge = ws_s_q[1] != ws_s_q[2];
  // PCM frames start on a rising frame pulse; the other modes start on either edge of word select.
  wire frm_start = (mode == SAC_MODE_PCM) ? (ws_s_q[1] && !ws_s_q[2]) :
    ws_edge;
  wire sdi = sdi_s_q[2];
  wire last = cnt_q == ($clog2(WORD_W+1))'(WORD_W - 1);

  function automatic logic [31:0] sext(input logic [WORD_W-1:0] w,
                                       input logic en);
    sext = en ? {{(32-WORD_W){w[WORD_W-1]}}, w} :
      {{(32-WORD_W){1'b0}}, w};
  endfunction

  // ****************************************************
  // Control register writes.
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_q <= SAC_CTRL2_RESET;
      on_q <= 1'b0;
      mask_q <= 6'h0;
    end else if (wr) begin
      if (paddr == SAC_CTRL2_OFS) begin
        ctrl2_q[15:8] <= pwdata[15:8] & SAC_CTRL2_MASK[15:8];
        if (!on_q) begin
          ctrl2_q[7:0] <= pwdata[7:0] & SAC_CTRL2_MASK[7:0];
        end
      end
      if (paddr == SAC_CTRL1_OFS) begin
        on_q <= pwdata[SAC_ON_BIT];
      end
      if (paddr == SAC_MASK_OFS) begin
        mask_q <= pwdata[5:0];
      end
    end
  end

  // ****************************************************
  // Link engine.
  // ****************************************************
  wire stall = st_q == SAC_HALT;
  wire rx_done = st_q == SAC_SHIFT && rise && last;
  wire tx_load = st_q == SAC_SHIFT && fall && cnt_q == '0;
  wire rx_overflow = rx_done && rxf_q;
  wire tx_underrun = tx_load && !txf_q && !mono_rep_q;
  wire frm = st_q == SAC_SHIFT && frm_start && cnt_q != '0 && audio;
  wire rd_rx = rd && paddr == SAC_RXD_OFS;
  wire wr_tx = wr && paddr == SAC_TXD_OFS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SAC_IDLE;
      cnt_q <= '0;
      right_q <= 1'b0;
      mono_rep_q <= 1'b0;
      tsh_q <= '0;
      rsh_q <= '0;
      link_sdo <= 1'b0;
      link_chan <= 1'b0;
    end else begin
      case (st_q)
        SAC_IDLE: begin
          cnt_q <= '0;
          if (on_q && (!audio || frm_start)) begin
            st_q <= SAC_SHIFT;
          end
        end
        SAC_SHIFT: begin
          if (!on_q) begin
            st_q <= SAC_IDLE;
          end else if ((rx_overflow && !ctrl2_q[SAC_IGNORE_RX_OVERFLOW_BIT]) ||
                       (tx_underrun && !ctrl2_q[SAC_IGNORE_TX_UNDERRUN_BIT])) begin
            st_q <= SAC_HALT;
          end
          if (tx_load) begin
            if (txf_q || mono_rep_q) begin
              tsh_q <= {txb_q[WORD_W-2:0], 1'b0};
            end else begin
              tsh_q <= '0;
            end
            link_chan <= right_q;
            right_q <= audio ? !right_q : 1'b0;
            mono_rep_q <= mono && !right_q && txf_q;
          end
          if (fall) begin
            link_sdo <= (tx_load ? (txf_q || mono_rep_q) && txb_q[WORD_W-1]
              : tsh_q[WORD_W-1]);
            if (!tx_load) begin
              tsh_q <= {tsh_q[WORD_W-2:0], 1'b0};
            end
          end
          if (rise) begin
            rsh_q <= {rsh_q[WORD_W-2:0], sdi};
            cnt_q <= last ? '0 : cnt_q + 1'b1;
          end
        end
        SAC_HALT: begin
          if (!on_q) begin
            st_q <= SAC_IDLE;
          end
        end
        default: st_q <= SAC_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Buffers.
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxb_q <= '0;
      rxf_q <= 1'b0;
      txb_q <= '0;
      txf_q <= 1'b0;
    end else begin
      if (rx_done && !stall && !(rxf_q && ctrl2_q[SAC_IGNORE_RX_OVERFLOW_BIT])) begin
        rxb_q <= {rsh_q[WORD_W-2:0], sdi};
        rxf_q <= 1'b1;
      end else if (rd_rx) begin
        rxf_q <= 1'b0;
      end
      if (wr_tx) begin
        txb_q <= pwdata[WORD_W-1:0];
        txf_q <= 1'b1;
      end else if (tx_load && !mono) begin
        txf_q <= 1'b0;
      end else if (tx_load && mono && !right_q) begin
        txf_q <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Status and interrupt.
  // ****************************************************
  logic [5:0] ev;
  always_comb begin
    ev = 6'h0;
    ev[SAC_ST_FRM] = frm && ctrl2_q[SAC_FRMEN_BIT];
    ev[SAC_ST_ROV] = rx_overflow && ctrl2_q[SAC_ROVEN_BIT];
    ev[SAC_ST_TUR] = tx_underrun && ctrl2_q[SAC_TUREN_BIT];
    ev[SAC_ST_HALT] = st_q == SAC_SHIFT && (
      (rx_overflow && !ctrl2_q[SAC_IGNORE_RX_OVERFLOW_BIT]) || (tx_underrun && !ctrl2_q[SAC_IGNORE_TX_UNDERRUN_BIT]));
    ev[SAC_ST_RXV] = rx_done;
    ev[SAC_ST_TXE] = tx_load;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 6'h0;
      irq <= 1'b0;
    end else begin
      if (wr && paddr == SAC_STAT_OFS) begin
        stat_q <= (stat_q & ~pwdata[5:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      irq <= |((stat_q | ev) & mask_q &
        ~((wr && paddr == SAC_STAT_OFS) ? pwdata[5:0] & ~ev : 6'h0));
    end
  end

  // ****************************************************
  // APB read path.
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          SAC_CTRL2_OFS: prdata <= {16'h0, ctrl2_q};
          SAC_CTRL1_OFS: prdata <= {31'h0, on_q};
          SAC_STAT_OFS: prdata <= {26'h0, stat_q};
          SAC_MASK_OFS: prdata <= {26'h0, mask_q};
          SAC_RXD_OFS: prdata <= sext(rxb_q, ctrl2_q[SAC_SGNEXT_BIT]);
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************************
  // Checks.
  // ****************************************************
  property p_frm;
    @(posedge pclk) disable iff (!presetn)
      (frm && !ctrl2_q[SAC_FRMEN_BIT] && !stat_q[SAC_ST_FRM]) |=>
      !stat_q[SAC_ST_FRM];
  endproperty
  a_frm: assert property (p_frm) else $error("frame event not gated");
  property p_rov;
    @(posedge pclk) disable iff (!presetn)
      (rx_overflow && ctrl2_q[SAC_ROVEN_BIT]) |=> stat_q[SAC_ST_ROV];
  endproperty
  a_rov: assert property (p_rov) else $error("overflow lost");
  property p_tur;
    @(posedge pclk) disable iff (!presetn)
      (tx_underrun && ctrl2_q[SAC_TUREN_BIT]) |=> stat_q[SAC_ST_TUR];
  endproperty
  a_tur: assert property (p_tur) else $error("underrun lost");
  property p_keep;
    @(posedge pclk) disable iff (!presetn)
      (rx_overflow && ctrl2_q[SAC_IGNORE_RX_OVERFLOW_BIT] && !rd_rx) |=> $stable(rxb_q);
  endproperty
  a_keep: assert property (p_keep) else $error("rx data overwritten");
  property p_hrov;
    @(posedge pclk) disable iff (!presetn)
      (rx_overflow && !ctrl2_q[SAC_IGNORE_RX_OVERFLOW_BIT] && on_q && st_q == SAC_SHIFT) |=>
      st_q == SAC_HALT;
  endproperty
  a_hrov: assert property (p_hrov) else $error("overflow no halt");
  property p_zero;
    @(posedge pclk) disable iff (!presetn)
      (tx_underrun && ctrl2_q[SAC_IGNORE_TX_UNDERRUN_BIT] && !wr_tx) |=> tsh_q == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("underrun not zero");
  property p_htur;
    @(posedge pclk) disable iff (!presetn)
      (tx_underrun && !ctrl2_q[SAC_IGNORE_TX_UNDERRUN_BIT] && on_q && st_q == SAC_SHIFT) |=>
      st_q == SAC_HALT;
  endproperty
  a_htur: assert property (p_htur) else $error("underrun no halt");
  property p_lock;
    @(posedge pclk) disable iff (!presetn)
      on_q |=> ctrl2_q[7:0] == $past(ctrl2_q[7:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("audio bits changed");
  property p_zhi;
    @(posedge pclk) disable iff (!presetn)
      ##1 prdata[31:WORD_W] == '0 || $past(ctrl2_q[SAC_SGNEXT_BIT]);
  endproperty
  a_zhi: assert property (p_zhi) else $error("upper bits set");
  c_halt: cover property (@(posedge pclk) st_q == SAC_HALT);
  c_rx: cover property (@(posedge pclk) rx_done && audio);
  c_mono: cover property (@(posedge pclk) tx_load && mono);

endmodule
`default_nettype wire

// file: test/sac_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module sac_link_model (
  // Link pins.
  output logic link_sck,
  output logic link_ws,
  output logic link_sdi,
  input wire logic link_sdo
);

  // ****
  // Serial peer.
  // ****
  // The clock stands low between words and sdi is turned over.
  initial begin
    link_sck = 1'b0;
    link_ws = 1'b0;
    link_sdi = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #7;
    for (int i = 15; i >= 0; i--) begin
      link_sdi = tx[i];
      #160;
      link_sck = 1'b1;
      rx[i] = link_sdo;
      #160;
      link_sck = 1'b0;
    end
    link_sdi = ~link_sdi;
  endtask

  task automatic aud(input logic [15:0] tx, output logic [15:0] rx);
    link_ws = ~link_ws;
    xfer(tx, rx);
  endtask

endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sac_pkg::*;

  // ****
  // Signals.
  // ****
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic link_sck, link_ws, link_sdi, link_sdo, link_chan;
  int fail_count = 0;
  int compares = 0;
  logic [31:0] rd;
  logic err;
  logic [15:0] got;

  always #20 pclk = ~pclk;

  sac_core dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_sck(link_sck),
    .link_ws(link_ws), .link_sdi(link_sdi), .link_sdo(link_sdo),
    .link_chan(link_chan), .irq(irq)
  );

  sac_link_model link (
    .link_sck(link_sck), .link_ws(link_ws), .link_sdi(link_sdi),
    .link_sdo(link_sdo)
  );

  // ****
  // Shared tasks.
  // ****
  task automatic print_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      print_verdict();
    end
  endtask

  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic word(input logic [15:0] rx_word);
    apb(1'b1, SAC_TXD_OFS, 32'h5a5a);
    link.xfer(rx_word, got);
    repeat (6) @(posedge pclk);
  endtask

  // ****
  // Scenarios.
  // ****
  task automatic t_regs();
    rdc("ctrl2 reset", SAC_CTRL2_OFS, 32'h0);
    apb(1'b1, 8'h18, 32'h1);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, SAC_CTRL2_OFS, 32'hffff_ffff);
    rdc("ctrl2 bits", SAC_CTRL2_OFS, 32'h0000_9f8b);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, SAC_CTRL2_OFS, 32'h80 | m);
      rdc("audio mode", SAC_CTRL2_OFS, 32'h80 | m);
    end
    apb(1'b1, SAC_CTRL2_OFS, 32'h0);
  endtask

  task automatic t_lock();
    apb(1'b1, SAC_CTRL1_OFS, 32'h1);
    apb(1'b1, SAC_CTRL2_OFS, 32'h0000_8aff);
    rdc("ctrl2 locked", SAC_CTRL2_OFS, 32'h0000_8a00);
    apb(1'b1, SAC_MASK_OFS, 32'h2);
  endtask

  task automatic t_rx_sign();
    apb(1'b1, SAC_TXD_OFS, 32'h1234);
    link.xfer(16'h8001, got);
    repeat (6) @(posedge pclk);
    rdc("rx signed", SAC_RXD_OFS, 32'hffff_8001);
  endtask

  task automatic t_overflow_kept();
    word(16'h7001);
    chk("tx word", {16'h0, got}, 32'h1234);
    word(16'h0f0f);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rdc("rx kept", SAC_RXD_OFS, 32'h0000_7001);
    apb(1'b0, SAC_STAT_OFS, 32'h0);
    chk("no halt", rd & 32'h8, 32'h0);
    apb(1'b1, SAC_STAT_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_overflow_halt();
    apb(1'b1, SAC_CTRL2_OFS, 32'h0000_0800);
    word(16'h8003);
    word(16'h9111);
    apb(1'b0, SAC_STAT_OFS, 32'h0);
    chk("halt", rd & 32'h8, 32'h8);
    rdc("rx plain", SAC_RXD_OFS, 32'h0000_9111);
  endtask

  task automatic t_underrun_halt();
    apb(1'b1, SAC_CTRL1_OFS, 32'h0);
    apb(1'b1, SAC_STAT_OFS, 32'h3f);
    apb(1'b1, SAC_CTRL2_OFS, 32'h0000_0200);
    apb(1'b1, SAC_CTRL1_OFS, 32'h1);
    repeat (2) link.xfer(16'h0, got);
    repeat (6) @(posedge pclk);
    apb(1'b0, SAC_STAT_OFS, 32'h0);
    chk("underrun halt", rd & 32'hc, 32'h8);
  endtask

  task automatic t_mono();
    apb(1'b1, SAC_CTRL1_OFS, 32'h0);
    apb(1'b1, SAC_STAT_OFS, 32'h3f);
    apb(1'b1, SAC_CTRL2_OFS, 32'h0000_0788);
    apb(1'b1, SAC_TXD_OFS, 32'h4321);
    apb(1'b1, SAC_CTRL1_OFS, 32'h1);
    link.aud(16'h0, got);
    link.aud(16'h0, got);
    chk("mono left", {16'h0, got}, 32'h4321);
    chk("left slot", {31'h0, link_chan}, 32'h0);
    link.aud(16'h0, got);
    chk("mono right", {16'h0, got}, 32'h4321);
    chk("right slot", {31'h0, link_chan}, 32'h1);
    link.aud(16'h0, got);
    chk("underrun zeros", {16'h0, got}, 32'h0);
    repeat (6) @(posedge pclk);
    apb(1'b0, SAC_STAT_OFS, 32'h0);
    chk("underrun event", rd & 32'hc, 32'h4);
  endtask

  // ****
  // Main sequence.
  // ****
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_lock();
    t_rx_sign();
    t_overflow_kept();
    t_overflow_halt();
    t_underrun_halt();
    t_mono();
    print_verdict();
  end

  initial begin
    #1000000;
    fail_count++;
    print_verdict();
  end

endmodule
`default_nettype wire
